// ---- hw/vfb_cfg.svh ----
`ifndef VFB_CFG_SVH
`define VFB_CFG_SVH
// Control space: 16 byte registers at every fourth address
`define VFB_NUM_REGS        16
`define VFB_REG_W           8
`define VFB_CTRL_BYTES      64
`define VFB_ADDR_W          13
`define VFB_RAM_ADDR_W      19
`define VFB_OFF_PITCH_LO    6'h00
`define VFB_OFF_REFRESH     6'h04
`define VFB_OFF_START_MID   6'h08
`define VFB_OFF_START_LO    6'h0C
`define VFB_OFF_SYNC_LO     6'h10
`define VFB_OFF_VLINES_FP   6'h14
`define VFB_OFF_VLINES_HI   6'h18
`define VFB_OFF_VBACK       6'h1C
`define VFB_OFF_SYNC_HI_EQ  6'h20
`define VFB_OFF_HSYNC_BEGIN 6'h24
`define VFB_OFF_HSYNC_WIDTH 6'h28
`define VFB_OFF_MID_EARLY   6'h2C
`define VFB_OFF_MIDLINE     6'h30
`define VFB_OFF_PIX_LATE    6'h34
`define VFB_OFF_PIX_HI      6'h38
`define VFB_OFF_CONFIG      6'h3C
`define VFB_CLUT_BASE       13'h1000
// Field positions in refresh_scan_options
`define VFB_REFRESHES_PER_LINE_HI         7
`define VFB_REFRESHES_PER_LINE_LO         5
`define VFB_INTERLACE_BIT   4
`define VFB_EXTSYNC_BIT     3
`define VFB_SETUP_HI        2
`define VFB_SETUP_LO        0
// Field positions in run_depth_sense_config
`define VFB_RUN_BIT         7
`define VFB_DEPTH_HI        6
`define VFB_DEPTH_LO        4
`define VFB_SENSE_BIT       3
`define VFB_START16_BIT     2
`define VFB_PITCH_HI_HI     1
`define VFB_PITCH_HI_LO     0
// Reset value of run_depth_sense_config: run and sense cleared
`define VFB_CONFIG_RST      8'h00
`define VFB_REG_RST         8'h00
`endif

// ---- hw/vfb_pkg.sv ----
package vfb_pkg;
   typedef enum logic [2:0] {
      VFB_DEPTH_16 = 3'h0,
      VFB_DEPTH_1  = 3'h4,
      VFB_DEPTH_2  = 3'h5,
      VFB_DEPTH_4  = 3'h6,
      VFB_DEPTH_8  = 3'h7
   } vfb_depth_t;
   typedef enum logic {VFB_BUS_IDLE, VFB_BUS_READ} vfb_host_state_t;
endpackage : vfb_pkg

// ---- hw/vfb_if.sv ----
`timescale 1ns/1ps
interface vfb_if;
   logic [12:0] addr;
   logic        ctrlSel;
   logic        ramSel;
   logic        wrEn;
   logic        rdEn;
   logic [31:0] wrData;
   logic [31:0] rdData;
   logic        size1;
   modport device (input addr, ctrlSel, ramSel, wrEn, rdEn, wrData, size1, output rdData);
   modport host   (output addr, ctrlSel, ramSel, wrEn, rdEn, wrData, size1, input rdData);
endinterface : vfb_if

// ---- hw/vfb_device.sv ----
`timescale 1ns/1ps
`include "vfb_cfg.svh"
// How it works
// - Sixteen byte registers, word spaced, 64 bytes
// - Control space decoded apart from RAM
// - Linear 32-bit frame buffer, 13-bit bus address, 8K in both builds
// - 17-bit start offset split over three registers
// - Software keeps screen inside populated memory
// - 10-bit pitch in longwords, split over two
// - Software keeps row bytes multiple of four
// - Refresh count per line from 04 bits 7:5
// - Software never writes zero refresh count
// - Bit 4 of 04 selects interlaced scan
// - Bit 3 of 04 selects external sync
// - Setup field 04 bits 2:0 sets sync time
// - Software computes setup from clock ratio
// - Effective pixel period scales inversely with depth
// - Config bit 3 inverts the address sense
// - Sense bit cleared at reset; host plain first
// - Inverted sense complements every address bit; size1 is not remapped
// - Inverted configuration keeps size1 high
// - Config register packing run, depth, sense, high bits
// - Reset clears run bit; no refresh until set
// - Depth code decodes to bits per pixel
module vfb_device #(
   parameter int LARGE_MEM = 1
) (
   // Host side
   vfb_if.device              bus,
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   // Configuration seen by the pixel and RAM engines
   output logic [16:0]        startOffset,
   output logic [9:0]         linePitch,
   output logic [2:0]         refreshesPerLine,
   output logic               interlaceOn,
   output logic               extSyncOn,
   output logic [2:0]         syncSetup,
   output logic               pixelEngineRun,
   output logic [4:0]         bitsPerPixel,
   output logic [3:0]         pixelPrescale,
   output logic               senseInvert,
   // Frame buffer RAM access port
   output logic               ramReq,
   output logic               ramWrite,
   output logic [18:0]        ramAddr,
   output logic [31:0]        ramWrData,
   output logic               refreshReq
);
   logic [7:0]  regs_reg [`VFB_NUM_REGS];
   logic [12:0] effAddr;
   logic        ctrlHit;
   logic [3:0]  regIdx;
   logic [31:0] rdData_reg;
   logic [2:0]  refreshCnt_reg;
   logic        lineTick;
   logic [7:0]  lineCnt_reg;
   logic        ctrlWrite;
   logic        ctrlRead;
   logic [7:0]  rdByte;
   // Named views of the registers that feed the engines
   logic [7:0]  pitchLowView;
   logic [7:0]  refreshOptsView;
   logic [7:0]  startMidView;
   logic [7:0]  startLowView;
   logic [7:0]  configView;

   // Register slot of each register, taken from its byte offset
   localparam int IDX_PITCH_LO     = int'(`VFB_OFF_PITCH_LO) >> 2;
   localparam int IDX_REFRESH      = int'(`VFB_OFF_REFRESH) >> 2;
   localparam int IDX_START_MID    = int'(`VFB_OFF_START_MID) >> 2;
   localparam int IDX_START_LO     = int'(`VFB_OFF_START_LO) >> 2;
   localparam int IDX_SYNC_LO      = int'(`VFB_OFF_SYNC_LO) >> 2;
   localparam int IDX_VLINES_FP    = int'(`VFB_OFF_VLINES_FP) >> 2;
   localparam int IDX_VLINES_HI    = int'(`VFB_OFF_VLINES_HI) >> 2;
   localparam int IDX_VBACK        = int'(`VFB_OFF_VBACK) >> 2;
   localparam int IDX_SYNC_HI_EQ   = int'(`VFB_OFF_SYNC_HI_EQ) >> 2;
   localparam int IDX_HSYNC_BEGIN  = int'(`VFB_OFF_HSYNC_BEGIN) >> 2;
   localparam int IDX_HSYNC_WIDTH  = int'(`VFB_OFF_HSYNC_WIDTH) >> 2;
   localparam int IDX_MID_EARLY    = int'(`VFB_OFF_MID_EARLY) >> 2;
   localparam int IDX_MIDLINE      = int'(`VFB_OFF_MIDLINE) >> 2;
   localparam int IDX_PIX_LATE     = int'(`VFB_OFF_PIX_LATE) >> 2;
   localparam int IDX_PIX_HI       = int'(`VFB_OFF_PIX_HI) >> 2;
   localparam int IDX_CONFIG       = int'(`VFB_OFF_CONFIG) >> 2;

   // The control pins arrive in inverted sense when the sense bit is set
   assign effAddr = senseInvert ? ~bus.addr : bus.addr;
   // Only the first 64 bytes hold registers; the rest of control space is unused
   assign ctrlHit = bus.ctrlSel && (effAddr < 13'(`VFB_CTRL_BYTES));
   assign regIdx  = effAddr[5:2];
   // A strobe outside the 64-byte window is refused: no write and a zero read
   assign ctrlWrite = ctrlHit && bus.wrEn;
   assign ctrlRead  = ctrlHit && bus.rdEn;

   // Register writes; every register, config included, resets to 8'h00
   // Each slot is its own flop group so a write touches only one slot
   genvar gi;
   generate
      for (gi = 0; gi < `VFB_NUM_REGS; gi++) begin : g_reg
         always_ff @(posedge ref_clk) begin
            if (!nrst) begin
               regs_reg[gi] <= (gi == IDX_CONFIG) ? `VFB_CONFIG_RST : `VFB_REG_RST;
            end else if (ctrlWrite && regIdx == 4'(gi)) begin
               regs_reg[gi] <= bus.wrData[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdData_reg <= 32'h0000_0000;
      end else if (ctrlRead) begin
         rdData_reg <= {24'h000000, rdByte};
      end else begin
         rdData_reg <= 32'h0000_0000;
      end
   end
   assign bus.rdData = rdData_reg;

   // Explicit slot mux; reading has no side effects on any register
   always_comb begin
      unique case (regIdx)
         4'(IDX_PITCH_LO):    rdByte = regs_reg[IDX_PITCH_LO];
         4'(IDX_REFRESH):     rdByte = regs_reg[IDX_REFRESH];
         4'(IDX_START_MID):   rdByte = regs_reg[IDX_START_MID];
         4'(IDX_START_LO):    rdByte = regs_reg[IDX_START_LO];
         4'(IDX_SYNC_LO):     rdByte = regs_reg[IDX_SYNC_LO];
         4'(IDX_VLINES_FP):   rdByte = regs_reg[IDX_VLINES_FP];
         4'(IDX_VLINES_HI):   rdByte = regs_reg[IDX_VLINES_HI];
         4'(IDX_VBACK):       rdByte = regs_reg[IDX_VBACK];
         4'(IDX_SYNC_HI_EQ):  rdByte = regs_reg[IDX_SYNC_HI_EQ];
         4'(IDX_HSYNC_BEGIN): rdByte = regs_reg[IDX_HSYNC_BEGIN];
         4'(IDX_HSYNC_WIDTH): rdByte = regs_reg[IDX_HSYNC_WIDTH];
         4'(IDX_MID_EARLY):   rdByte = regs_reg[IDX_MID_EARLY];
         4'(IDX_MIDLINE):     rdByte = regs_reg[IDX_MIDLINE];
         4'(IDX_PIX_LATE):    rdByte = regs_reg[IDX_PIX_LATE];
         4'(IDX_PIX_HI):      rdByte = regs_reg[IDX_PIX_HI];
         4'(IDX_CONFIG):      rdByte = regs_reg[IDX_CONFIG];
      endcase
   end

   // Views used by the field slices below
   assign pitchLowView    = regs_reg[IDX_PITCH_LO];
   assign refreshOptsView = regs_reg[IDX_REFRESH];
   assign startMidView    = regs_reg[IDX_START_MID];
   assign startLowView    = regs_reg[IDX_START_LO];
   assign configView      = regs_reg[IDX_CONFIG];

   // Field extraction
   assign startOffset = {configView[`VFB_START16_BIT], startMidView, startLowView};
   assign linePitch   = {configView[`VFB_PITCH_HI_HI:`VFB_PITCH_HI_LO], pitchLowView};
   assign refreshesPerLine = refreshOptsView[`VFB_REFRESHES_PER_LINE_HI:`VFB_REFRESHES_PER_LINE_LO];
   assign interlaceOn = refreshOptsView[`VFB_INTERLACE_BIT];
   assign extSyncOn   = refreshOptsView[`VFB_EXTSYNC_BIT];
   assign syncSetup   = refreshOptsView[`VFB_SETUP_HI:`VFB_SETUP_LO];
   assign pixelEngineRun = configView[`VFB_RUN_BIT];
   assign senseInvert = configView[`VFB_SENSE_BIT];

   // Depth decode; reserved codes fall back to 16 bits
   always_comb begin
      unique case (vfb_pkg::vfb_depth_t'(configView[`VFB_DEPTH_HI:`VFB_DEPTH_LO]))
         vfb_pkg::VFB_DEPTH_1:  begin bitsPerPixel = 5'h01; pixelPrescale = 4'hF; end
         vfb_pkg::VFB_DEPTH_2:  begin bitsPerPixel = 5'h02; pixelPrescale = 4'h7; end
         vfb_pkg::VFB_DEPTH_4:  begin bitsPerPixel = 5'h04; pixelPrescale = 4'h3; end
         vfb_pkg::VFB_DEPTH_8:  begin bitsPerPixel = 5'h08; pixelPrescale = 4'h1; end
         default:               begin bitsPerPixel = 5'h10; pixelPrescale = 4'h0; end
      endcase
   end

   // RAM data space: full 32-bit word path, 19-bit byte address fed from 13 bus bits; both configs wrap at 8K
   assign ramReq    = bus.ramSel && !bus.ctrlSel;
   assign ramWrite  = ramReq && bus.wrEn;
   // Small build forces the top byte-address bit low, but only 13 address bits reach ramAddr, so both builds wrap at 8K
   always_comb begin
      if (LARGE_MEM != 0) begin
         ramAddr = 19'(effAddr);
      end else begin
         ramAddr = {1'b0, 18'(effAddr)};
      end
   end
   assign ramWrData = bus.wrData;

   // Crude line timer: a refresh burst per line, held off until the run bit is set
   // Line length is a fixed stand-in; the horizontal timing registers are not decoded
   always_ff @(posedge ref_clk) begin
      if (!nrst || !pixelEngineRun) begin
         lineCnt_reg <= 8'h00;
      end else begin
         lineCnt_reg <= lineCnt_reg + 8'h01;
      end
   end
   assign lineTick = pixelEngineRun && (lineCnt_reg == 8'hFF);

   // Refresh count is loaded once per line and counted down each cycle, so a zero count gives no refresh
   always_ff @(posedge ref_clk) begin
      if (!nrst || !pixelEngineRun) begin
         refreshCnt_reg <= 3'h0;
      end else if (lineTick) begin
         refreshCnt_reg <= refreshesPerLine;
      end else if (refreshCnt_reg != 3'h0) begin
         refreshCnt_reg <= refreshCnt_reg - 3'h1;
      end
   end
   assign refreshReq = refreshCnt_reg != 3'h0;
endmodule : vfb_device

// ---- hw/vfb_host.sv ----
`timescale 1ns/1ps
`include "vfb_cfg.svh"
module vfb_host (
   // Device side
   vfb_if.host              bus,
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Software port
   input  wire logic [12:0] swAddr,
   input  wire logic        swCtrl,
   input  wire logic [31:0] swWrData,
   input  wire logic        swWrite,
   input  wire logic        swRead,
   output logic [31:0]      swRdData,
   // Host view of device sense; follows writes to the config register
   output logic             hostInvert
);
   logic invert_reg;
   logic senseWrite;

   // Sense starts plain after reset and tracks what the host writes
   assign senseWrite = swWrite && swCtrl && swAddr[5:0] == `VFB_OFF_CONFIG;
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         invert_reg <= 1'b0;
      end else if (senseWrite) begin
         invert_reg <= swWrData[`VFB_SENSE_BIT];
      end
   end
   assign hostInvert = invert_reg;

   // The new sense applies from the access after the config write
   assign bus.addr    = invert_reg ? ~swAddr : swAddr;
   assign bus.ctrlSel = swCtrl && (swWrite || swRead);
   assign bus.ramSel  = !swCtrl && (swWrite || swRead);
   assign bus.wrEn    = swWrite;
   assign bus.rdEn    = swRead;
   // Software keeps pitch, refresh count and setup legal; no checks here
   assign bus.wrData  = swWrData;
   assign bus.size1   = 1'b1;
   assign swRdData    = bus.rdData;
endmodule : vfb_host

// ---- tb/vfb_props.sv ----
`timescale 1ns/1ps
module vfb_props (
   // Clock, reset and interface signals
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic [12:0] addr,
   input wire logic        ctrlSel,
   input wire logic        ramSel,
   input wire logic        wrEn,
   input wire logic        rdEn,
   input wire logic [31:0] wrData,
   input wire logic [31:0] rdData,
   input wire logic        size1
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Plain-sense control register write followed at once by a read of it
   sequence wr_rd;
      (wrEn && ctrlSel && addr[12:6] == 7'h00) ##1 (rdEn && ctrlSel && addr == $past(addr));
   endsequence
   rd_idle_zero_a: assert property (!rdEn |=> rdData == 32'h0)
      else $error("read data outside read slot");
   rd_upper_zero_a: assert property (rdEn |=> rdData[31:8] == 24'h0)
      else $error("upper read bits not zero");
   readback_a: assert property (wr_rd |=> rdData[7:0] == $past(wrData[7:0], 2))
      else $error("read back differs from write");
   unmapped_zero_a: assert property ((rdEn && ctrlSel && addr[12] == 1'b0
      && addr[11:6] != 6'h00) |=> rdData == 32'h0)
      else $error("unmapped read not zero");
   reset_zero_a: assert property ($rose(nrst) |-> rdData == 32'h0 [*2])
      else $error("read data not clear after reset");
   strobe_excl_a: assert property (!(wrEn && rdEn))
      else $error("read and write strobes together");
   space_excl_a: assert property (!(ctrlSel && ramSel))
      else $error("both spaces selected");
   size_high_a: assert property (size1)
      else $error("size1 not high");
   cover property (wr_rd);
   cover property (wrEn && ctrlSel && addr == 13'h003C);
   cover property (rdEn && ctrlSel && addr == 13'h1FC3);
endmodule : vfb_props

// ---- tb/test_video_fb_config_registers.sv ----
`timescale 1ns/1ps
module test_video_fb_config_registers;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [12:0] swAddr = 13'h0000;
   logic        swCtrl = 1'b1;
   logic [31:0] swWrData = 32'h0;
   logic        swWrite = 1'b0;
   logic        swRead = 1'b0;
   logic [31:0] swRdData, ramWrData;
   logic [16:0] startOffset;
   logic [9:0]  linePitch;
   logic [18:0] ramAddr;
   logic [4:0]  bitsPerPixel;
   logic [3:0]  pixelPrescale;
   logic [2:0]  refreshesPerLine, syncSetup;
   logic        hostInvert, interlaceOn, extSyncOn, pixelEngineRun, senseInvert;
   logic        ramReq, ramWrite, refreshReq;
   int          err_count = 0, cmp_count = 0, cycles = 0, hits;
   always #2 ref_clk = ~ref_clk;
   vfb_if vfb_if_inst ();
   vfb_host vfb_host_inst (.bus(vfb_if_inst), .ref_clk, .nrst, .swAddr, .swCtrl, .swWrData,
      .swWrite, .swRead, .swRdData, .hostInvert);
   vfb_device vfb_device_inst (.bus(vfb_if_inst), .ref_clk, .nrst, .startOffset, .linePitch,
      .refreshesPerLine, .interlaceOn, .extSyncOn, .syncSetup, .pixelEngineRun, .bitsPerPixel,
      .pixelPrescale, .senseInvert, .ramReq, .ramWrite, .ramAddr, .ramWrData, .refreshReq);
   vfb_props vfb_props_inst (.ref_clk, .nrst, .addr(vfb_if_inst.addr),
      .ctrlSel(vfb_if_inst.ctrlSel), .ramSel(vfb_if_inst.ramSel), .wrEn(vfb_if_inst.wrEn),
      .rdEn(vfb_if_inst.rdEn), .wrData(vfb_if_inst.wrData), .rdData(vfb_if_inst.rdData),
      .size1(vfb_if_inst.size1));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Strobes stay up until the next call, so calls follow each other with no gap
   task automatic drive(input logic w, input logic r, input logic [12:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      swWrite <= w;
      swRead <= r;
      swAddr <= a;
      swWrData <= {24'h0, d};
   endtask : drive
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      drive(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      drive(1'b0, 1'b1, a, 8'h00);
      drive(1'b0, 1'b0, a, 8'h00);
      #1 chk(swRdData, {24'h0, exp});
   endtask : rd
   task automatic idle(input int n);
      hits = 0;
      repeat (n) begin
         drive(1'b0, 1'b0, 13'h0000, 8'h00);
         #1 hits += int'(refreshReq === 1'b1);
      end
   endtask : idle
   task automatic t_regs;
      for (int i = 0; i < 16; i++) rd(13'(i * 4), 8'h00);
      chk(pixelEngineRun, 32'h0);
      chk(vfb_if_inst.size1, 32'h1);
      for (int i = 0; i < 16; i++) begin
         wr(13'(i * 4), 8'(i * 17 + 3));
         rd(13'(i * 4), 8'(i * 17 + 3));
      end
      wr(13'h0040, 8'hEE);
      rd(13'h0040, 8'h00);
      swCtrl = 1'b0;
      wr(13'h0000, 8'hEE);
      #1 chk({ramReq, ramWrite, ramAddr}, 32'h180000);
      chk(ramWrData, 32'hEE);
      idle(1);
      swCtrl = 1'b1;
      rd(13'h0000, 8'h03);
      $display("register access test done");
   endtask : t_regs
   task automatic t_fields;
      wr(13'h0000, 8'hA0);
      wr(13'h0004, 8'hB5);
      wr(13'h0008, 8'h12);
      wr(13'h000C, 8'h34);
      wr(13'h003C, 8'hF5);
      idle(1);
      chk(startOffset, 32'h11234);
      chk(linePitch, 32'h1A0);
      chk({refreshesPerLine, interlaceOn, extSyncOn, syncSetup}, 32'hB5);
      chk({pixelEngineRun, bitsPerPixel}, 32'h28);
      wr(13'h0004, 8'h4A);
      idle(300);
      chk({refreshesPerLine, interlaceOn, extSyncOn, syncSetup}, 32'h4A);
      idle(256);
      chk(hits, 32'h2);
      for (int i = 0; i < 5; i++) begin
         wr(13'h003C, {1'b0, 3'(i + 4), 4'h0});
         idle(256);
         chk(bitsPerPixel, 32'(1 << i));
         chk(pixelPrescale, 32'((16 >> i) - 1));
         chk(hits, 32'h0);
      end
      $display("field decode test done");
   endtask : t_fields
   task automatic t_sense;
      wr(13'h003C, 8'h08);
      idle(1);
      chk({senseInvert, hostInvert}, 32'h3);
      rd(13'h003C, 8'h08);
      nrst <= 1'b0;
      idle(2);
      nrst <= 1'b1;
      chk(senseInvert, 32'h0);
      rd(13'h003C, 8'h00);
      $display("address sense test done");
   endtask : t_sense
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         test_done;
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      t_regs;
      t_fields;
      t_sense;
      test_done;
   end
endmodule : test_video_fb_config_registers
